//--- src/synth_pkg.sv
// constants shared by the serial control port of the tuning synthesiser
// assumes a single 100 MHz clock domain
package synth_pkg;
  // ============================================================
  // bus address
  localparam logic [4:0] ADDR_FIXED = 5'h18;
  localparam logic [1:0] ADDR_SEL_ALWAYS = 2'h1;
  // ============================================================
  // write byte layout
  localparam int PUMP_CURRENT_BIT = 6;
  localparam int PHASE_TEST_BIT = 5;
  localparam int PUMP_DISABLE_BIT = 4;
  localparam int DRIVE_OFF_BIT = 0;
  localparam int DIV_BITS = 15;
  localparam int PRESCALE = 8;
  // ============================================================
  // reset values
  localparam logic [14:0] DIV_RESET = 15'h0000;
  localparam logic [7:0] PUMP_RESET = 8'h8e;
  localparam logic [5:0] PORT_RESET = 6'h00;
  // ============================================================
  // timing: 4 MHz reference divided to the comparison rate
  localparam int CLK_HZ = 100000000;
  localparam int REF_HZ = 4000000;
  localparam int COMP_MHZ_X10000 = 78125;
  localparam int REF_DIV = (REF_HZ * 10) / COMP_MHZ_X10000 * 1000 / 1000
                           + 0;
  localparam int REF_TO_COMP = 512;
  localparam int CLK_PER_REF = CLK_HZ / REF_HZ;
endpackage

//--- src/ratio_divider.sv
// programmable divider chain: /8 prescale then /ratio, plus phase compare
// assumes oscillator edges arrive as one-cycle enable pulses
`timescale 1ns/100ps
`default_nettype none
module ratio_divider import synth_pkg::*; #(
  parameter int W = DIV_BITS
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic osc_tick_in,
  input wire logic comp_tick_in,
  input wire logic [W-1:0] ratio_in,
  output logic div_tick_out,
  output logic locked_out
);
  initial begin
    if (W < 2) $error("ratio width too small");
  end
  typedef struct packed {
    logic [2:0] pre;
    logic [W-1:0] cnt;
    logic tick;
    logic pend;
    logic [3:0] good;
    logic locked;
  } st_s;
  st_s r, n;
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (osc_tick_in) begin
      n.pre = r.pre + 3'h1;
      if (r.pre == 3'(PRESCALE - 1)) begin // R5
        if (r.cnt + W'(1) >= ratio_in) begin
          n.cnt = '0;
          n.tick = 1'b1;
        end else begin
          n.cnt = r.cnt + W'(1);
        end
      end
    end
    // lock: divided and comparison edges pair up for several periods
    if (comp_tick_in && !r.tick) begin
      n.pend = 1'b1;
      if (r.pend) n.good = '0;
    end
    if (r.tick) begin
      if (r.pend || comp_tick_in) begin
        if (r.good != 4'hf) n.good = r.good + 4'h1;
      end else begin
        n.good = '0;
      end
      n.pend = 1'b0;
    end
    n.locked = (r.good == 4'hf); // R17
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) r <= '0;
    else r <= n;
  end
  assign div_tick_out = r.tick;
  assign locked_out = r.locked;
endmodule
`default_nettype wire

//--- src/level_converter.sv
// five-band level code from four threshold comparator results
// assumes comparator inputs are already synchronous
`timescale 1ns/100ps
`default_nettype none
module level_converter (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [3:0] above_in,
  output logic [2:0] code_out
);
  typedef struct packed {
    logic [2:0] code;
  } st_s;
  st_s r, n;
  // above_in bits: 0.15, 0.3, 0.45, 0.6 of supply
  always_comb begin
    n = r;
    if (above_in[3]) n.code = 3'h4; // R19
    else if (above_in[2]) n.code = 3'h3;
    else if (above_in[1]) n.code = 3'h2;
    else if (above_in[0]) n.code = 3'h1;
    else n.code = 3'h0;
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) r <= '0;
    else r <= n;
  end
  assign code_out = r.code;
endmodule
`default_nettype wire

//--- src/synth_serial_control_port.sv
// serial bus slave and control registers of a tuning synthesiser
// assumes scl/sda and port levels are synchronous samples of the pins
// Function
// [R1] first data bit picks divider or pump byte
// [R2] accept bytes until stop condition
// [R3] partial byte discarded, old value kept
// [R4] 15-bit ratio, high then low, msb first
// [R5] fixed divide-by-eight before ratio divider
// [R6] 4 MHz reference gives 7.8125 kHz compare
// [R7] pump current bit selects high current
// [R8] pump disable bit turns pump off
// [R9] drive amp off bit disables amplifier
// [R10] phase test routes clocks to lines 6,7
// [R11] master sends fixed ones in pump byte
// [R12] port byte drives six open outputs
// [R13] address 11000, selector matched against line 7
// [R14] read returns status byte msb first
// [R15] power flag set on loss, cleared read-stop
// [R16] outputs high impedance after power-up
// [R17] lock bit shows loop lock
// [R18] sense bits report lines 0,2,3
// [R19] five-band converter code from line 1
// [R20] address lsb high means read
// [R21] acknowledge address and each data byte
// [R22] master acks to receive more status
// [R23] ratio applied only after both bytes
`timescale 1ns/100ps
`default_nettype none
module synth_serial_control_port import synth_pkg::*; (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic supply_low_in,
  input wire logic ref_tick_in,
  input wire logic osc_tick_in,
  input wire logic [1:0] line7_select_in,
  input wire logic port_line_0_in,
  input wire logic port_line_2_in,
  input wire logic port_line_3_in,
  input wire logic [3:0] line1_above_in,
  output logic [14:0] divider_ratio_out,
  output logic pump_current_high_out,
  output logic pump_disable_out,
  output logic drive_amp_off_out,
  output logic comp_tick_out,
  output logic [5:0] port_sink_on_out
);
  // ============================================================
  // reset release
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  typedef enum logic [2:0] {
    IDLE, ADDR, ADDR_ACK, WDATA, WACK, RDATA, RACK
  } phase_e;

  typedef struct packed {
    phase_e ph;
    logic scl_d;
    logic sda_d;
    logic [7:0] sh;
    logic [3:0] nbit;
    logic rd;
    logic want_port;
    logic want_low;
    logic [6:0] div_hi;
    logic [14:0] ratio;
    logic [7:0] pump;
    logic [5:0] ports;
    logic por;
    logic [8:0] ref_cnt;
    logic comp;
    logic sda_low;
    logic [7:0] status;
  } st_s;

  st_s r, n;
  logic locked;
  logic div_tick;
  logic [2:0] level_code;
  logic scl_rise, scl_fall, start_c, stop_c;

  ratio_divider #(.W(DIV_BITS)) u_div (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .osc_tick_in(osc_tick_in),
    .comp_tick_in(r.comp),
    .ratio_in(r.ratio),
    .div_tick_out(div_tick),
    .locked_out(locked)
  );

  level_converter u_lvl (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .above_in(line1_above_in),
    .code_out(level_code)
  );

  assign scl_rise = scl_in && !r.scl_d;
  assign scl_fall = !scl_in && r.scl_d;
  assign start_c = r.scl_d && scl_in && r.sda_d && !sda_in;
  assign stop_c = r.scl_d && scl_in && !r.sda_d && sda_in;

  // ============================================================
  // bus engine and registers
  always_comb begin
    n = r;
    n.scl_d = scl_in;
    n.sda_d = sda_in;
    n.comp = 1'b0;
    if (supply_low_in) n.por = 1'b1; // R15
    // comparison rate from the reference
    if (ref_tick_in) begin
      if (r.ref_cnt == 9'(REF_TO_COMP - 1)) begin // R6
        n.ref_cnt = '0;
        n.comp = 1'b1;
      end else begin
        n.ref_cnt = r.ref_cnt + 9'h1;
      end
    end
    if (stop_c) begin
      // a stop ends everything; the shift register is simply dropped
      // a nacked read is already idle, so the phase is not looked at
      if (r.rd && !supply_low_in) n.por = 1'b0; // R15
      n.rd = 1'b0;
      n.ph = IDLE; // R2 R3
      n.sda_low = 1'b0;
    end else if (start_c) begin
      n.ph = ADDR; // R3
      n.rd = 1'b0;
      n.nbit = '0;
      n.sda_low = 1'b0;
    end else if (scl_rise) begin
      case (r.ph)
        ADDR, WDATA: begin
          n.sh = {r.sh[6:0], sda_in};
          n.nbit = r.nbit + 4'h1;
        end
        RACK: begin
          if (sda_in) n.ph = IDLE; // R22
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (r.ph)
        ADDR: begin
          if (r.nbit == 4'h8) begin
            n.nbit = '0;
            if (r.sh[7:3] == ADDR_FIXED && // R13
                (r.sh[2:1] == ADDR_SEL_ALWAYS ||
                 r.sh[2:1] == line7_select_in)) begin
              n.ph = ADDR_ACK;
              n.sda_low = 1'b1; // R21
              n.rd = r.sh[0]; // R20
              n.want_low = 1'b0; // R1
              n.want_port = 1'b0;
            end else begin
              n.ph = IDLE;
            end
          end
        end
        ADDR_ACK: begin
          n.sda_low = 1'b0;
          if (r.rd) begin
            n.ph = RDATA;
            n.status = {r.por, locked, port_line_0_in, // R14 R17
                        port_line_2_in, port_line_3_in, // R18
                        level_code}; // R19
            n.sda_low = ~r.por;
            n.nbit = 4'h1;
          end else begin
            n.ph = WDATA;
          end
        end
        WDATA: begin
          if (r.nbit == 4'h8) begin
            n.nbit = '0;
            n.ph = WACK;
            n.sda_low = 1'b1; // R21
            if (r.want_low) begin
              n.ratio = {r.div_hi, r.sh}; // R4 R23
              n.want_low = 1'b0;
            end else if (r.want_port) begin
              n.ports = {r.sh[7:6], r.sh[3:0]}; // R12
              n.want_port = 1'b0;
            end else if (!r.sh[7]) begin // R1
              n.div_hi = r.sh[6:0]; // R4
              n.want_low = 1'b1;
            end else begin
              n.pump = r.sh; // R1 R11
              n.want_port = 1'b1;
            end
          end
        end
        WACK: begin
          n.sda_low = 1'b0;
          n.ph = WDATA; // R2
        end
        RDATA: begin
          if (r.nbit == 4'h8) begin
            n.ph = RACK;
            n.sda_low = 1'b0;
          end else begin
            n.sda_low = ~r.status[3'(7 - r.nbit)]; // R14
            n.nbit = r.nbit + 4'h1;
          end
        end
        RACK: begin
          n.ph = RDATA;
          n.nbit = 4'h1;
          n.sda_low = ~r.status[7];
        end
        default: n.ph = IDLE;
      endcase
    end
    // pump byte followed by a port byte: whatever byte comes after a
    // pump byte is taken as the port byte, whatever its msb
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.ph <= IDLE;
      r.pump <= PUMP_RESET;
      r.ratio <= DIV_RESET;
      r.ports <= PORT_RESET; // R16
      r.por <= 1'b1; // R15
    end else begin
      r <= n;
    end
  end

  // ============================================================
  // registered outputs
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      divider_ratio_out <= DIV_RESET;
      pump_current_high_out <= 1'b0;
      pump_disable_out <= 1'b0;
      drive_amp_off_out <= 1'b0;
      comp_tick_out <= 1'b0;
      port_sink_on_out <= PORT_RESET; // R16
    end else begin
      sda_out <= 1'b0;
      sda_oe_n_out <= ~n.sda_low;
      divider_ratio_out <= r.ratio;
      pump_current_high_out <= r.pump[PUMP_CURRENT_BIT]; // R7
      pump_disable_out <= r.pump[PUMP_DISABLE_BIT]; // R8
      drive_amp_off_out <= r.pump[DRIVE_OFF_BIT]; // R9
      comp_tick_out <= r.comp;
      port_sink_on_out <= r.ports;
      if (r.pump[PHASE_TEST_BIT]) begin // R10
        port_sink_on_out[4] <= r.comp;
        port_sink_on_out[5] <= div_tick;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/bus_master_model.sv
// bus master model: drives scl and sda, 17-clock bit period
// assumes sda has a pull-up, so a released line reads high
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  input wire logic clock_in,
  input wire logic sda_in,
  output var logic scl_out,
  output var logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic start_cond();
    @(posedge clock_in);
    sda_out <= 1'b0;
    wait_n(8);
    scl_out <= 1'b0;
  endtask
  // sda moves 5 edges after the fall, clear of the device's answer
  task automatic bit_xfer(input logic b, output logic r);
    wait_n(5);
    sda_out <= b;
    wait_n(4);
    scl_out <= 1'b1;
    wait_n(8);
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic byte_xfer(input logic [7:0] d, input logic ack_m,
      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
    bit_xfer(ack_m, ack);
  endtask
  task automatic stop_cond();
    wait_n(5);
    sda_out <= 1'b0;
    wait_n(4);
    scl_out <= 1'b1;
    wait_n(8);
    sda_out <= 1'b1;
    wait_n(16);
  endtask
endmodule
`default_nettype wire

//--- sim/synth_serial_control_port_monitor.sv
// pin assertions for the serial control port
// bound to the top module; one clock domain
`timescale 1ns/100ps
`default_nettype none
module port_monitor (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_oe_n_out,
  input wire logic [14:0] divider_ratio_out,
  input wire logic pump_current_high_out,
  input wire logic pump_disable_out,
  input wire logic drive_amp_off_out,
  input wire logic comp_tick_out,
  input wire logic [5:0] port_sink_on_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ====================
  // sequences
  sequence comp_gap;
    !comp_tick_out [*8];
  endsequence
  // ====================
  // properties
  a_oe_low_phase: assert property ($changed(sda_oe_n_out) |->
    !$past(scl_in) && !scl_in) else $error("sda moved near scl high");
  a_oe_reset_idle: assert property ($rose(rstn_in) |-> sda_oe_n_out)
    else $error("sda pulled after reset");
  a_ports_reset: assert property ($rose(rstn_in) |->
    port_sink_on_out == 6'h00) else $error("ports on after reset");
  a_ratio_reset: assert property ($rose(rstn_in) |->
    divider_ratio_out == 15'h0000) else $error("ratio not cleared");
  a_ratio_scl_low: assert property ($changed(divider_ratio_out) |->
    !scl_in && !$past(scl_in)) else $error("ratio moved mid-bit");
  a_pump_scl_low: assert property ($changed({pump_current_high_out,
    pump_disable_out, drive_amp_off_out}) |-> !scl_in)
    else $error("pump bits moved mid-bit");
  a_ports_scl_low: assert property ($changed(port_sink_on_out[3:0])
    |-> !scl_in) else $error("ports moved mid-bit");
  a_comp_single: assert property (comp_tick_out |=> comp_gap)
    else $error("comparison pulse too wide");
endmodule
bind synth_serial_control_port port_monitor u_port_monitor (.clock_in,
  .rstn_in, .scl_in, .sda_oe_n_out, .divider_ratio_out,
  .pump_current_high_out, .pump_disable_out, .drive_amp_off_out,
  .comp_tick_out, .port_sink_on_out);
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the serial control port
// open-drain sda with pull-up, bus driven by the master model
`timescale 1ns/100ps
`default_nettype none
module tb import synth_pkg::*; ;
  logic clock_in, rstn_in, supply_low, ref_tick, osc_tick;
  logic p0, p2, p3, m_scl, m_sda, sda_d, sda_oe_n, pch, pdis, doff, comp;
  logic [1:0] sel7, cnt;
  logic [3:0] above;
  logic [14:0] ratio;
  logic [5:0] ports;
  int error_cnt, compares;
  wire sda = m_sda & (sda_oe_n | sda_d);
  synth_serial_control_port u_synth_serial_control_port (
    .clock_in(clock_in), .rstn_in(rstn_in), .scl_in(m_scl),
    .sda_in(sda), .sda_out(sda_d), .sda_oe_n_out(sda_oe_n),
    .supply_low_in(supply_low), .ref_tick_in(ref_tick),
    .osc_tick_in(osc_tick), .line7_select_in(sel7),
    .port_line_0_in(p0), .port_line_2_in(p2), .port_line_3_in(p3),
    .line1_above_in(above), .divider_ratio_out(ratio),
    .pump_current_high_out(pch), .pump_disable_out(pdis),
    .drive_amp_off_out(doff), .comp_tick_out(comp),
    .port_sink_on_out(ports));
  bus_master_model u_bus_master_model (.clock_in(clock_in),
    .sda_in(sda), .scl_out(m_scl), .sda_out(m_sda));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cnt <= cnt + 2'h1;
    ref_tick <= (cnt == 2'h0);
    osc_tick <= cnt[0];
  end
  // ====================
  // helpers
  task automatic chk(input string nm, input logic [15:0] exp,
      input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic a_exp);
    logic [7:0] q;
    logic a;
    u_bus_master_model.byte_xfer(d, 1'b1, q, a);
    chk("ack", {15'h0, a_exp}, {15'h0, a});
  endtask
  task automatic rd(input logic [6:0] exp, input int n);
    logic [7:0] q;
    logic a;
    u_bus_master_model.start_cond();
    wr(8'hc3, 1'b0);
    for (int i = 1; i <= n; i++) begin
      u_bus_master_model.byte_xfer(8'hff, i == n, q, a);
      chk("status", {9'h0, exp}, {9'h0, q[7], q[5:0]});
    end
    u_bus_master_model.stop_cond();
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_ratio();
    u_bus_master_model.start_cond();
    wr(8'hc2, 1'b0);
    wr(8'h12, 1'b0);
    chk("ratio", 16'h0, {1'b0, ratio});
    wr(8'h34, 1'b0);
    chk("ratio", 16'h1234, {1'b0, ratio});
    wr(8'h01, 1'b0);
    wr(8'hff, 1'b0);
    chk("ratio", 16'h01ff, {1'b0, ratio});
    wr(8'h7f, 1'b0);
    u_bus_master_model.stop_cond();
  endtask
  task automatic t_abort();
    logic b;
    u_bus_master_model.start_cond();
    wr(8'hc2, 1'b0);
    wr(8'h15, 1'b0);
    for (int i = 0; i < 3; i++) u_bus_master_model.bit_xfer(1'b0, b);
    u_bus_master_model.stop_cond();
    chk("ratio", 16'h01ff, {1'b0, ratio});
  endtask
  task automatic t_pump();
    u_bus_master_model.start_cond();
    wr(8'hc2, 1'b0);
    wr(8'hdf, 1'b0);
    chk("pump", 16'h7, {13'h0, pch, pdis, doff});
    wr(8'h35, 1'b0);
    chk("ports", 16'h05, {10'h0, ports});
    wr(8'h8e, 1'b0);
    chk("pump", 16'h0, {13'h0, pch, pdis, doff});
    wr(8'hc0, 1'b0);
    chk("ports", 16'h30, {10'h0, ports});
    u_bus_master_model.stop_cond();
  endtask
  task automatic t_route();
    logic seen;
    seen = 1'b0;
    u_bus_master_model.start_cond();
    wr(8'hc2, 1'b0);
    wr(8'hae, 1'b0);
    wr(8'h00, 1'b0);
    u_bus_master_model.stop_cond();
    // comparison pulses come every 2048 clocks here
    for (int i = 0; i < 3000 && !seen; i++) begin
      @(posedge clock_in);
      if (comp === 1'b1) begin
        seen = 1'b1;
        chk("route", 16'h1, {15'h0, ports[4]});
      end
    end
    chk("route_seen", 16'h1, {15'h0, seen});
  endtask
  task automatic t_addr();
    @(posedge clock_in);
    sel7 <= 2'h2;
    for (int s = 0; s < 5; s++) begin
      u_bus_master_model.start_cond();
      wr(s == 4 ? 8'ha2 : {ADDR_FIXED, s[1:0], 1'b0}, s != 1 && s != 2);
      u_bus_master_model.stop_cond();
    end
  endtask
  task automatic t_read();
    @(posedge clock_in);
    p2 <= 1'b0;
    above <= 4'h3;
    rd(7'h42, 2);
    @(posedge clock_in);
    {p0, p2, p3} <= 3'h2;
    above <= 4'hf;
    rd(7'h14, 1);
    @(posedge clock_in);
    supply_low <= 1'b1;
    @(posedge clock_in);
    supply_low <= 1'b0;
    rd(7'h54, 1);
  endtask
  initial begin
    {rstn_in, supply_low, ref_tick, osc_tick, cnt} = 6'h0;
    {p0, p2, p3, sel7, above} = 9'h1c;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    chk("ports", 16'h0, {10'h0, ports});
    chk("oe", 16'h1, {15'h0, sda_oe_n});
    chk("sda", 16'h0, {15'h0, sda_d});
    t_ratio();
    t_abort();
    t_pump();
    t_route();
    t_addr();
    t_read();
    wrap_up();
  end
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
